// File: common/epm_pkg.sv
// constants of the ethernet power mode manager: register offsets,
// field positions, mode codes, reset values and timer pacing.
// assumes a 16-bit register port with byte addresses.
package epm_pkg;
	// register byte offsets
	localparam logic [7:0] GLOBAL_RESET_OFS = 8'h26;
	localparam logic [7:0] INTERRUPT_ENABLE_OFS = 8'h90;
	localparam logic [7:0] INTERRUPT_STATUS_OFS = 8'h92;
	localparam logic [7:0] POWER_MGMT_EVENT_CONTROL_OFS = 8'hd4;
	localparam logic [7:0] SLEEP_WAKE_TIMER_OFS = 8'h7e;
	localparam logic [7:0] CHIP_CONFIGURATION_OFS = 8'h08;
	localparam logic [7:0] RECEIVE_FRAME_DATA_POINTER_OFS = 8'h86;
	localparam logic [7:0] PORT_CONTROL_LINK_DIAG_OFS = 8'hf4;

	// power_mgmt_event_control fields
	localparam int MODE_LSB = 0;
	localparam int WAKE_TO_NORMAL_BIT = 6;
	localparam int AUTO_WAKE_BIT = 7;
	localparam int PME_ENABLE_BIT = 8;
	// interrupt enable / status energy bit
	localparam int ENERGY_IRQ_BIT = 2;
	// sleep_wake_timer fields
	localparam int GO_SLEEP_LSB = 0;
	localparam int WAKE_UP_LSB = 8;
	// chip_configuration fields
	localparam int CFG_BUS8_BIT = 6;
	localparam int CFG_BUS16_BIT = 7;
	localparam int CFG_BIG_ENDIAN_BIT = 10;
	// receive_frame_data_pointer endian select
	localparam int RXFDP_ENDIAN_BIT = 11;
	// port_control_link_diag power saving enable
	localparam int PORT_SAVE_BIT = 10;

	// power mode codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_ENERGY = 2'h1;
	localparam logic [1:0] MODE_SOFT_DOWN = 2'h2;
	localparam logic [1:0] MODE_SAVING = 2'h3;

	// reset values
	localparam logic [15:0] REG_RESET = 16'h0000;

	// timer pacing: one sleep/wake unit
	localparam int CLK_KHZ = 40000;
	localparam int TIME_UNIT_US = 1000;
	localparam int TICK_CYCLES = (TIME_UNIT_US * CLK_KHZ) / 1000;

	// internal power states, one-hot
	typedef enum logic [4:0] {
		PS_NORMAL = 5'h01,
		PS_ED_AWAKE = 5'h02,
		PS_ED_LOW = 5'h04,
		PS_SOFT_DOWN = 5'h08,
		PS_SAVING = 5'h10
	} epm_state_t;
endpackage

// File: rtl/epm_dwell_timer.sv
// dwell timer: counts time units while a condition holds.
// assumes tick is a one-cycle pulse from the owner's divider.
`timescale 1ns/1ps
module epm_dwell_timer #(
	parameter int LIMIT_W = 8 // width of the limit field
) (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // async reset, active high
	input wire logic hold, // condition being timed
	input wire logic tick, // one time unit elapsed
	input wire logic [LIMIT_W-1:0] limit, // units the condition must exceed
	output logic expired // condition held longer than limit
);
	logic [LIMIT_W:0] count;
	wire logic past = count > {1'b0, limit};
	wire logic saturated = &count;

	// restart whenever the condition drops; saturate so a long hold stays expired
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
		end else if (!hold) begin
			count <= '0;
		end else if (tick && !saturated) begin
			count <= count + 1'b1;
		end
	end

	// strictly longer than the limit, never equal
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			expired <= 1'b0;
		end else begin
			expired <= hold && past;
		end
	end
endmodule

// File: rtl/epm_strap_latch.sv
// strap capture: samples straps once, on the first edge after reset.
// assumes straps are stable while reset is asserted and just after.
`timescale 1ns/1ps
module epm_strap_latch (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // async reset, active high
	input wire logic endian_strap, // high selects big endian
	input wire logic bus_width_strap, // high selects 16-bit bus
	input wire logic eeprom_present_strap, // high when an eeprom is fitted
	input wire logic wideBusMode, // device built for the 32-bit bus
	output logic bigEndianStrap, // latched endian strap
	output logic bus16Strap, // latched 16-bit selection
	output logic bus8Strap // latched 8-bit selection
);
	logic taken;

	// reset can only load constants, so the straps are sampled after release
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			taken <= 1'b0;
			bigEndianStrap <= 1'b0;
			bus16Strap <= 1'b0;
			bus8Strap <= 1'b0;
		end else if (!taken) begin
			taken <= 1'b1;
			bigEndianStrap <= endian_strap;
			// width strap counts only without eeprom and off the 32-bit bus
			bus16Strap <= !eeprom_present_strap && !wideBusMode && bus_width_strap;
			bus8Strap <= !eeprom_present_strap && !wideBusMode && !bus_width_strap;
		end
	end
endmodule

// File: rtl/epm_power_manager.sv
// power mode manager: mode register, block gating, energy-detect
// sleep/wake sequencing, wake signalling and strap-derived config.
// assumes host accesses arrive as one-cycle strobes synchronous to core_clk.
`timescale 1ns/1ps
module epm_power_manager #(
	parameter int TICK_CYCLES = epm_pkg::TICK_CYCLES // core cycles per time unit
) (
	input wire logic core_clk, // 40 MHz system clock
	input wire logic sys_rst, // async reset, active high
	input wire logic [7:0] hostAddr, // register byte address
	input wire logic hostRd, // read strobe, one cycle
	input wire logic hostWr, // write strobe, one cycle
	input wire logic [1:0] hostByteEn_n, // byte enables, active low
	input wire logic [15:0] hostWrData, // write data
	output logic [15:0] hostRdData, // read data, registered
	output logic hostRdValid, // read data valid, one cycle
	input wire logic cableEnergy, // receiver sees energy on the cable
	input wire logic autoNegEnable, // auto-negotiation enabled
	input wire logic endian_strap, // endian strap pin
	input wire logic bus_width_strap, // bus width strap pin
	input wire logic eeprom_present_strap, // eeprom strap pin
	input wire logic wideBusMode, // 32-bit bus build
	output logic power_event_out, // power management event pin
	output logic irqOut, // interrupt request, active high
	output logic clkEnable, // internal clock running
	output logic macEnable, // mac powered
	output logic hostIfEnable, // host interface serving accesses
	output logic phyTxEnable, // phy transmitter powered
	output logic phyRxEnable, // full phy receiver powered
	output logic energyDetectOn, // receiver energy detector powered
	output logic packetEnable, // transmit and receive allowed
	output logic bigEndian, // effective byte order
	output logic bus16 // effective 16-bit bus selection
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// register storage
	logic [15:0] power_mgmt_event_control;
	logic [15:0] interrupt_enable;
	logic [15:0] sleep_wake_timer;
	logic [15:0] global_reset;
	logic [15:0] receive_frame_data_pointer;
	logic [15:0] port_control_link_diag;
	logic energyFlag;
	logic lowPower;
	logic wakeSeen;
	logic [TICK_W-1:0] tickCount;
	logic tick;
	logic sleepExpired;
	logic wakeExpired;
	logic bigEndianStrap;
	logic bus16Strap;
	logic bus8Strap;
	epm_pkg::epm_state_t pwrState;

	// byte-lane merge shared by every writable register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
			input logic [1:0] benN);
		merge = {benN[1] ? old[15:8] : val[15:8], benN[0] ? old[7:0] : val[7:0]};
	endfunction

	// field decode
	wire logic [1:0] mode = power_mgmt_event_control[epm_pkg::MODE_LSB +: 2];
	wire logic autoWake = power_mgmt_event_control[epm_pkg::AUTO_WAKE_BIT];
	wire logic wakeToNormal = power_mgmt_event_control[epm_pkg::WAKE_TO_NORMAL_BIT];
	wire logic pmeEnable = power_mgmt_event_control[epm_pkg::PME_ENABLE_BIT];
	wire logic [7:0] goSleepTime = sleep_wake_timer[epm_pkg::GO_SLEEP_LSB +: 8];
	wire logic [7:0] wakeUpTime = sleep_wake_timer[epm_pkg::WAKE_UP_LSB +: 8];
	wire logic modeEnergy = mode == epm_pkg::MODE_ENERGY;
	wire logic modeSoft = mode == epm_pkg::MODE_SOFT_DOWN;
	wire logic modeSaving = mode == epm_pkg::MODE_SAVING;

	// current power state from mode and energy-detect substate
	epm_pkg::epm_state_t curState;
	always_comb begin
		case (mode)
			epm_pkg::MODE_ENERGY: begin
				curState = lowPower ? epm_pkg::PS_ED_LOW : epm_pkg::PS_ED_AWAKE;
			end
			epm_pkg::MODE_SOFT_DOWN: curState = epm_pkg::PS_SOFT_DOWN;
			epm_pkg::MODE_SAVING: curState = epm_pkg::PS_SAVING;
			default: curState = epm_pkg::PS_NORMAL;
		endcase
	end

	// host port decode; only a wake read gets through while asleep
	wire logic hostLive = !modeSoft && !(modeEnergy && lowPower);
	wire logic hitGrr = hostAddr == epm_pkg::GLOBAL_RESET_OFS;
	wire logic hitIer = hostAddr == epm_pkg::INTERRUPT_ENABLE_OFS;
	wire logic hitIsr = hostAddr == epm_pkg::INTERRUPT_STATUS_OFS;
	wire logic hitPm = hostAddr == epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS;
	wire logic hitSwt = hostAddr == epm_pkg::SLEEP_WAKE_TIMER_OFS;
	wire logic hitCfg = hostAddr == epm_pkg::CHIP_CONFIGURATION_OFS;
	wire logic hitRxf = hostAddr == epm_pkg::RECEIVE_FRAME_DATA_POINTER_OFS;
	wire logic hitPort = hostAddr == epm_pkg::PORT_CONTROL_LINK_DIAG_OFS;
	wire logic wrLive = hostWr && hostLive;
	wire logic wakeRead = hostRd && hitGrr && !hostLive;
	wire logic isrClear = wrLive && hitIsr && !hostByteEn_n[0]
		&& hostWrData[epm_pkg::ENERGY_IRQ_BIT];

	// energy-detect event: rising edge of the wake condition in low power
	wire logic wakeCond = modeEnergy && lowPower && wakeExpired;
	wire logic energyEvent = wakeCond && !wakeSeen;
	wire logic autoReturn = energyEvent && autoWake;
	wire logic toNormalMode = autoReturn && wakeToNormal;

	// power saving gate holds only while every entry condition holds
	wire logic savingGate = modeSaving && autoNegEnable && !cableEnergy
		&& port_control_link_diag[epm_pkg::PORT_SAVE_BIT];

	// chip configuration read view
	wire logic [15:0] cfgView = (16'h0001 << epm_pkg::CFG_BIG_ENDIAN_BIT) & {16{bigEndianStrap}}
		| (16'h0001 << epm_pkg::CFG_BUS16_BIT) & {16{bus16Strap}}
		| (16'h0001 << epm_pkg::CFG_BUS8_BIT) & {16{bus8Strap}};
	wire logic [15:0] isrView = {15'h0000, energyFlag} << epm_pkg::ENERGY_IRQ_BIT;

	// read mux; unmapped addresses and sleeping accesses other than global reset read zero
	logic [15:0] rdMux;
	always_comb begin
		rdMux = 16'h0000;
		if (hitGrr) begin
			rdMux = global_reset;
		end else if (!hostLive) begin
			rdMux = 16'h0000;
		end else if (hitIer) begin
			rdMux = interrupt_enable;
		end else if (hitIsr) begin
			rdMux = isrView;
		end else if (hitPm) begin
			rdMux = power_mgmt_event_control;
		end else if (hitSwt) begin
			rdMux = sleep_wake_timer;
		end else if (hitCfg) begin
			rdMux = cfgView;
		end else if (hitRxf) begin
			rdMux = receive_frame_data_pointer;
		end else if (hitPort) begin
			rdMux = port_control_link_diag;
		end
	end

	// time-unit divider for the sleep and wake timers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tickCount <= '0;
			tick <= 1'b0;
		end else begin
			tick <= tickCount == TICK_LAST;
			tickCount <= (tickCount == TICK_LAST) ? '0 : tickCount + 1'b1;
		end
	end

	// quiet cable timer, runs only while awake in energy mode
	epm_dwell_timer #(.LIMIT_W(8)) sleepTimer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.hold(modeEnergy && !lowPower && !cableEnergy),
		.tick(tick),
		.limit(goSleepTime),
		.expired(sleepExpired)
	);

	// energy-present timer, runs only in the low power state
	epm_dwell_timer #(.LIMIT_W(8)) wakeTimer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.hold(modeEnergy && lowPower && cableEnergy),
		.tick(tick),
		.limit(wakeUpTime),
		.expired(wakeExpired)
	);

	// strap capture after reset release
	epm_strap_latch straps (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.endian_strap(endian_strap),
		.bus_width_strap(bus_width_strap),
		.eeprom_present_strap(eeprom_present_strap),
		.wideBusMode(wideBusMode),
		.bigEndianStrap(bigEndianStrap),
		.bus16Strap(bus16Strap),
		.bus8Strap(bus8Strap)
	);

	// mode control register; hardware wake paths override host writes
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_mgmt_event_control <= epm_pkg::REG_RESET;
		end else if (wakeRead && modeSoft) begin
			power_mgmt_event_control[epm_pkg::MODE_LSB +: 2] <= epm_pkg::MODE_NORMAL;
		end else if (toNormalMode) begin
			power_mgmt_event_control[epm_pkg::MODE_LSB +: 2] <= epm_pkg::MODE_NORMAL;
		end else if (wrLive && hitPm) begin
			power_mgmt_event_control <= merge(power_mgmt_event_control, hostWrData, hostByteEn_n);
		end
	end

	// plain storage registers, frozen while the host side sleeps
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			interrupt_enable <= epm_pkg::REG_RESET;
			sleep_wake_timer <= epm_pkg::REG_RESET;
			global_reset <= epm_pkg::REG_RESET;
			receive_frame_data_pointer <= epm_pkg::REG_RESET;
			port_control_link_diag <= epm_pkg::REG_RESET;
		end else if (wrLive) begin
			if (hitIer) interrupt_enable <= merge(interrupt_enable, hostWrData, hostByteEn_n);
			if (hitSwt) sleep_wake_timer <= merge(sleep_wake_timer, hostWrData, hostByteEn_n);
			if (hitGrr) global_reset <= merge(global_reset, hostWrData, hostByteEn_n);
			if (hitRxf) begin
				receive_frame_data_pointer <= merge(receive_frame_data_pointer, hostWrData,
					hostByteEn_n);
			end
			if (hitPort) begin
				port_control_link_diag <= merge(port_control_link_diag, hostWrData,
					hostByteEn_n);
			end
		end
	end

	// energy wake status; a new event beats a same-cycle clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			energyFlag <= 1'b0;
		end else if (energyEvent) begin
			energyFlag <= 1'b1;
		end else if (isrClear) begin
			energyFlag <= 1'b0;
		end
	end

	// energy-detect substate: sleep on quiet cable, wake on auto-wake event or host read
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lowPower <= 1'b0;
			wakeSeen <= 1'b0;
		end else begin
			wakeSeen <= wakeCond;
			if (!modeEnergy) begin
				lowPower <= 1'b0;
			end else if (wakeRead || autoReturn) begin
				lowPower <= 1'b0;
			end else if (sleepExpired) begin
				lowPower <= 1'b1;
			end
		end
	end

	// registered host answer, one cycle after the read strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hostRdData <= 16'h0000;
			hostRdValid <= 1'b0;
		end else begin
			hostRdValid <= hostRd;
			hostRdData <= hostRd ? rdMux : 16'h0000;
		end
	end

	// block gating per power state; saving keeps tx up, drops idle rx
	logic nClk, nMac, nHost, nTx, nRx, nEd;
	always_comb begin
		nClk = 1'b1;
		nMac = 1'b1;
		nHost = 1'b1;
		nTx = 1'b1;
		nRx = 1'b1;
		nEd = 1'b1;
		case (curState)
			epm_pkg::PS_NORMAL, epm_pkg::PS_ED_AWAKE: begin
				nClk = 1'b1;
			end
			epm_pkg::PS_ED_LOW: begin
				nClk = 1'b0;
				nMac = 1'b0;
				nHost = 1'b0;
				nTx = 1'b0;
				nRx = 1'b0;
			end
			epm_pkg::PS_SOFT_DOWN: begin
				nClk = 1'b0;
				nMac = 1'b0;
				nHost = 1'b0;
				nTx = 1'b0;
				nRx = 1'b0;
				nEd = 1'b0;
			end
			epm_pkg::PS_SAVING: begin
				nRx = !savingGate;
			end
			default: begin
				nClk = 1'b1;
			end
		endcase
	end

	// every output leaves from a flip-flop
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwrState <= epm_pkg::PS_NORMAL;
			clkEnable <= 1'b1;
			macEnable <= 1'b1;
			hostIfEnable <= 1'b1;
			phyTxEnable <= 1'b1;
			phyRxEnable <= 1'b1;
			energyDetectOn <= 1'b1;
			packetEnable <= 1'b1;
			power_event_out <= 1'b0;
			irqOut <= 1'b0;
			bigEndian <= 1'b0;
			bus16 <= 1'b0;
		end else begin
			pwrState <= curState;
			clkEnable <= nClk;
			macEnable <= nMac;
			hostIfEnable <= nHost;
			phyTxEnable <= nTx;
			phyRxEnable <= nRx;
			energyDetectOn <= nEd;
			packetEnable <= nMac && nTx && nRx;
			power_event_out <= energyFlag && pmeEnable;
			irqOut <= energyFlag && interrupt_enable[epm_pkg::ENERGY_IRQ_BIT];
			// strap high wins; otherwise software picks the byte order
			bigEndian <= bigEndianStrap
				|| receive_frame_data_pointer[epm_pkg::RXFDP_ENDIAN_BIT];
			bus16 <= bus16Strap;
		end
	end
endmodule

// File: testbench/epm_power_manager_sva.sv
// checker for the power mode manager, bound to its top-level ports.
// assumes straps hold still around reset release.
`timescale 1ns/1ps
module epm_power_manager_sva (
	input wire logic core_clk, // clock
	input wire logic sys_rst, // async reset
	input wire logic [7:0] hostAddr, // byte address
	input wire logic hostRd, // read strobe
	input wire logic [15:0] hostRdData, // read data
	input wire logic hostRdValid, // read valid
	input wire logic cableEnergy, // cable energy
	input wire logic endian_strap, // endian strap
	input wire logic bus_width_strap, // width strap
	input wire logic eeprom_present_strap, // eeprom strap
	input wire logic wideBusMode, // 32-bit build
	input wire logic power_event_out, // event pin
	input wire logic irqOut, // interrupt
	input wire logic clkEnable, // clock on
	input wire logic macEnable, // mac on
	input wire logic hostIfEnable, // host if on
	input wire logic phyTxEnable, // tx on
	input wire logic phyRxEnable, // rx on
	input wire logic packetEnable, // packets allowed
	input wire logic bigEndian, // byte order
	input wire logic bus16 // 16-bit bus
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// wake command and reset release as named steps
	sequence s_gr_read;
		hostRd && hostAddr == epm_pkg::GLOBAL_RESET_OFS;
	endsequence
	sequence s_release;
		$fell(sys_rst);
	endsequence
	property p_rd_answer;
		hostRdValid == $past(hostRd);
	endproperty
	property p_reset_vals;
		s_release |-> clkEnable && macEnable && hostIfEnable && packetEnable && !irqOut;
	endproperty
	property p_gate_off;
		!clkEnable |-> !macEnable && !hostIfEnable && !phyTxEnable && !phyRxEnable;
	endproperty
	property p_saving;
		clkEnable && !phyRxEnable |-> macEnable && hostIfEnable && phyTxEnable;
	endproperty
	property p_packet;
		packetEnable |-> clkEnable && macEnable && phyTxEnable;
	endproperty
	property p_endian;
		s_release |-> ##2 (bigEndian == endian_strap);
	endproperty
	property p_width;
		s_release |-> ##2 (bus16 == (bus_width_strap && !eeprom_present_strap && !wideBusMode));
	endproperty
	property p_pme;
		$rose(power_event_out) |-> $past(cableEnergy, 2);
	endproperty
	property p_irq;
		$rose(irqOut) |-> $past(cableEnergy, 2);
	endproperty
	property p_wake_read;
		(!clkEnable ##0 s_gr_read) |-> ##[1:4] clkEnable;
	endproperty
	property p_refused;
		!hostIfEnable && hostRd && hostAddr != epm_pkg::GLOBAL_RESET_OFS |=> hostRdData == 16'h0000;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
	a_gate_off: assert property (p_gate_off) else $error("block on with clock off");
	a_saving: assert property (p_saving) else $error("saving gated too much");
	a_packet: assert property (p_packet) else $error("packets while powered down");
	a_endian: assert property (p_endian) else $error("endian strap not latched");
	a_width: assert property (p_width) else $error("width strap not latched");
	a_pme: assert property (p_pme) else $error("event pin without energy");
	a_irq: assert property (p_irq) else $error("interrupt without energy");
	a_wake_read: assert property (p_wake_read) else $error("wake read ignored");
	a_refused: assert property (p_refused) else $error("read served while down");
endmodule

// File: testbench/epm_host_model.sv
// host cpu model: one-cycle read and write strobes on the register port.
// assumes calls are made from the bench; everything moves on falling edges.
`timescale 1ns/1ps
module epm_host_model (
	input wire logic core_clk, // system clock
	output logic [7:0] hostAddr, // byte address
	output logic hostRd, // read strobe
	output logic hostWr, // write strobe
	output logic [1:0] hostByteEn_n, // byte enables, active low
	output logic [15:0] hostWrData, // write data
	input wire logic [15:0] hostRdData, // read data
	input wire logic hostRdValid // read data valid
);
	initial begin
		hostAddr = 8'h5a;
		hostRd = 1'b0;
		hostWr = 1'b0;
		hostByteEn_n = 2'h3;
		hostWrData = 16'ha5a5;
	end
	// idle bus scrambles address and data so stale values never pass
	task automatic idle();
		hostRd = 1'b0;
		hostWr = 1'b0;
		hostByteEn_n = 2'h3;
		hostAddr = ~hostAddr;
		hostWrData = ~hostWrData;
	endtask
	// mode changes are plain full-width writes
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk);
		hostAddr = a;
		hostWrData = d;
		hostByteEn_n = 2'h0;
		hostWr = 1'b1;
		@(negedge core_clk);
		idle();
	endtask
	// answer stands only from the taking edge to the next; no answer reads 16'hbad0
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge core_clk);
		hostAddr = a;
		hostByteEn_n = 2'h0;
		hostRd = 1'b1;
		@(negedge core_clk);
		d = (hostRdValid === 1'b1) ? hostRdData : 16'hbad0;
		idle();
	endtask
endmodule

// File: testbench/tb_top.sv
// bench for the power mode manager: host model calls plus output checks.
// assumes a shortened time unit of four clock cycles.
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cableEnergy = 1'b0;
	logic autoNegEnable = 1'b1;
	logic endianStrap = 1'b0;
	logic widthStrap = 1'b1;
	logic [7:0] hostAddr;
	logic hostRd, hostWr, hostRdValid;
	logic [1:0] hostByteEn_n;
	logic [15:0] hostWrData, hostRdData, rdv;
	logic power_event_out, irqOut, clkEnable, macEnable, hostIfEnable, phyTxEnable;
	logic phyRxEnable, energyDetectOn, packetEnable, bigEndian, bus16;
	int n_mismatch = 0;
	int n_checks = 0;
	int n;
	// all status and gating outputs, not the read port, folded into one word for compact comparison
	wire logic [15:0] fl = {5'h00, bus16, bigEndian, power_event_out, irqOut, clkEnable,
		macEnable, hostIfEnable, phyTxEnable, phyRxEnable, energyDetectOn, packetEnable};
	wire logic [2:0] wv = {irqOut, clkEnable, phyRxEnable};
	always #12.5 core_clk = ~core_clk;
	epm_host_model host (.core_clk(core_clk), .hostAddr(hostAddr), .hostRd(hostRd),
		.hostWr(hostWr), .hostByteEn_n(hostByteEn_n), .hostWrData(hostWrData),
		.hostRdData(hostRdData), .hostRdValid(hostRdValid));
	epm_power_manager #(.TICK_CYCLES(4)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
		.hostAddr(hostAddr), .hostRd(hostRd), .hostWr(hostWr), .hostByteEn_n(hostByteEn_n),
		.hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
		.cableEnergy(cableEnergy), .autoNegEnable(autoNegEnable), .endian_strap(endianStrap),
		.bus_width_strap(widthStrap), .eeprom_present_strap(1'b0), .wideBusMode(1'b0),
		.power_event_out(power_event_out), .irqOut(irqOut), .clkEnable(clkEnable),
		.macEnable(macEnable), .hostIfEnable(hostIfEnable), .phyTxEnable(phyTxEnable),
		.phyRxEnable(phyRxEnable), .energyDetectOn(energyDetectOn),
		.packetEnable(packetEnable), .bigEndian(bigEndian), .bus16(bus16));
	task automatic conclude();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait on one watched output, cycles counted in cnt
	task automatic waitv(input int i, input logic v, output int cnt);
		cnt = 0;
		while (wv[i] !== v) begin
			@(negedge core_clk);
			cnt++;
			if (cnt > 400) begin
				n_mismatch++;
				$display("MISMATCH t=%0t wait ran out", $time);
				conclude();
			end
		end
	endtask
	initial begin
		repeat (12) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge core_clk);
		chk(fl, 16'h047f);
		host.rd(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, rdv);
		chk(rdv, 16'h0000);
		host.rd(epm_pkg::CHIP_CONFIGURATION_OFS, rdv);
		chk(rdv, 16'h0080);
		host.rd(8'h02, rdv);
		chk(rdv, 16'h0000);
		// power saving: only the receiver and packet enable drop while the line is quiet
		host.wr(epm_pkg::PORT_CONTROL_LINK_DIAG_OFS, 16'h0400);
		host.wr(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, 16'h0003);
		repeat (2) @(negedge core_clk);
		chk(fl, 16'h047a);
		cableEnergy = 1'b1;
		waitv(0, 1'b1, n);
		chk(fl, 16'h047f);
		// energy detect, manual wake: sleep after 3 units, wake after 2
		host.wr(epm_pkg::SLEEP_WAKE_TIMER_OFS, 16'h0203);
		host.wr(epm_pkg::INTERRUPT_ENABLE_OFS, 16'h0004);
		host.wr(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, 16'h0101);
		cableEnergy = 1'b0;
		waitv(1, 1'b0, n);
		chk({15'h0000, n > 12 && n <= 24}, 16'h0001);
		chk(fl, 16'h0402);
		host.rd(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, rdv);
		chk(rdv, 16'h0000);
		cableEnergy = 1'b1;
		waitv(2, 1'b1, n);
		chk({15'h0000, n > 8 && n <= 24}, 16'h0001);
		chk(fl, 16'h0582);
		host.rd(epm_pkg::GLOBAL_RESET_OFS, rdv);
		waitv(1, 1'b1, n);
		chk(fl, 16'h05ff);
		host.rd(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, rdv);
		chk(rdv, 16'h0101);
		host.rd(epm_pkg::INTERRUPT_STATUS_OFS, rdv);
		chk(rdv & 16'h0004, 16'h0004);
		host.wr(epm_pkg::INTERRUPT_STATUS_OFS, 16'h0004);
		repeat (2) @(negedge core_clk);
		chk(fl, 16'h047f);
		// auto wake with return to normal operation
		host.wr(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, 16'h00c1);
		cableEnergy = 1'b0;
		waitv(1, 1'b0, n);
		cableEnergy = 1'b1;
		waitv(1, 1'b1, n);
		repeat (2) @(negedge core_clk);
		chk(fl, 16'h04ff);
		host.rd(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, rdv);
		chk(rdv, 16'h00c0);
		host.wr(epm_pkg::INTERRUPT_STATUS_OFS, 16'h0004);
		// soft power down freezes registers until the wake read
		host.wr(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, 16'h0002);
		repeat (2) @(negedge core_clk);
		chk(fl, 16'h0400);
		host.wr(epm_pkg::SLEEP_WAKE_TIMER_OFS, 16'hffff);
		host.rd(epm_pkg::GLOBAL_RESET_OFS, rdv);
		waitv(1, 1'b1, n);
		host.rd(epm_pkg::SLEEP_WAKE_TIMER_OFS, rdv);
		chk(rdv, 16'h0203);
		host.rd(epm_pkg::POWER_MGMT_EVENT_CONTROL_OFS, rdv);
		chk(rdv, 16'h0000);
		// unstrapped byte order follows the frame pointer bit
		host.wr(epm_pkg::RECEIVE_FRAME_DATA_POINTER_OFS, 16'h0800);
		repeat (2) @(negedge core_clk);
		chk(fl, 16'h067f);
		// second reset in mid-run with the other strap levels
		sys_rst = 1'b1;
		endianStrap = 1'b1;
		widthStrap = 1'b0;
		repeat (3) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge core_clk);
		chk(fl, 16'h027f);
		host.rd(epm_pkg::CHIP_CONFIGURATION_OFS, rdv);
		chk(rdv, 16'h0440);
		conclude();
	end
endmodule
bind epm_power_manager epm_power_manager_sva u_sva (.core_clk(core_clk), .sys_rst(sys_rst),
	.hostAddr(hostAddr), .hostRd(hostRd), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
	.cableEnergy(cableEnergy), .endian_strap(endian_strap), .bus_width_strap(bus_width_strap),
	.eeprom_present_strap(eeprom_present_strap), .wideBusMode(wideBusMode),
	.power_event_out(power_event_out), .irqOut(irqOut), .clkEnable(clkEnable),
	.macEnable(macEnable), .hostIfEnable(hostIfEnable), .phyTxEnable(phyTxEnable),
	.phyRxEnable(phyRxEnable), .packetEnable(packetEnable), .bigEndian(bigEndian),
	.bus16(bus16));
